// File: design/cbim_top.sv
// Identifier part of the CAN message buffers: three transmit buffers and one
// receive buffer, an Avalon-MM register port and a protocol engine port.
// Assumes the protocol engine runs on clk and drives its strobes synchronously.
//
// Behaviour
// R1: Extended identifier is 29 bits, bit 28 most significant and sent first.
// R2: The numerically smallest identifier has the highest priority.
// R3: Extended layout: byte1 holds 20..18 and 17..15, byte2 14..7, byte3 6..0.
// R4: Software writes 1 to the substitute-remote-request bit of transmit buffers.
// R5: Receive buffers store the substitute-remote-request bit as received.
// R6: Transmit format flag selects standard (0) or extended (1) identifier.
// R7: Receive format flag is written with the received frame's format.
// R8: Transmit remote flag sets RTR; extended mapping keeps it in byte3 bit 0.
// R9: Receive remote flag holds the received RTR value.
// R10: Standard identifier is 11 bits, bit 10 most significant and sent first.
// R11: Standard byte0 holds identifier bits 10..3.
// R12: Standard byte1 holds bits 2..0, remote flag at 4, format flag at 3.
// R13: Receive bytes readable when full; transmit bytes when selected and empty.
// R14: Buffer contents and unused bits carry no defined value.
// R15: Standard transmit ignores byte1 bits 2..0 and bytes 2 and 3.
`default_nettype none

module cbim_top
  import cbim_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic           ce,
  input  wire cbim_avs_req_t  avs_req,
  output logic [31:0]         avs_readdata,
  output logic                avs_waitrequest,
  output logic                tx_valid,
  output logic [TXW-1:0]      tx_idx,
  output cbim_frame_t         tx_frame,
  input  wire logic           tx_done,
  input  wire logic [TXW-1:0] tx_done_idx,
  input  wire logic           rx_store,
  input  wire cbim_frame_t    rx_frame,
  output logic                rx_full,
  output logic                rx_overrun
);

  cbim_state_t               s_q;
  cbim_state_t               s_d;
  cbim_frame_t [NTX-1:0]     pk_frame;
  logic [NTX-1:0][31:0]      pk_key;
  logic [3:0][7:0]           rx_bytes;

  ////////////////////////////////////////////////////////////////////////////
  // One packer per transmit buffer
  genvar gi;
  generate
    for (gi = 0; gi < NTX; gi++) begin : g_pack
      cbim_pack u_pack (
        .id_bytes (s_q.tx_id[gi]),
        .frame    (pk_frame[gi]),
        .arb_key  (pk_key[gi])
      );
    end
  endgenerate

  // Received header to stored byte layout
  cbim_unpack u_unpack (
    .frame    (rx_frame),
    .id_bytes (rx_bytes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the answer
  logic       req_new;
  logic       wr_go;
  logic [7:0] wbyte;

  assign req_new         = (avs_req.read | avs_req.write) & ~s_q.ack;
  assign wr_go           = s_q.ack & avs_req.write & avs_req.byteenable[0];
  assign wbyte           = avs_req.writedata[7:0];
  assign avs_waitrequest = (avs_req.read | avs_req.write) & ~s_q.ack;

  ////////////////////////////////////////////////////////////////////////////
  // Selected transmit buffer and its access window
  logic [TXW-1:0] sel_idx;
  logic           tx_open;

  always_comb begin
    sel_idx = '0;
    for (int i = NTX - 1; i >= 0; i--) begin
      if (s_q.sel[i]) begin
        sel_idx = TXW'(i);
      end
    end
  end

  // Only a buffer software owns may be touched
  assign tx_open = |(s_q.sel & s_q.empty);                                // R13

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h00000000;
    if (avs_req.address == OFS_RX_ID0) begin
      if (s_q.rx_full) rd_val = {24'h000000, s_q.rx_id[0]};               // R13
    end else if (avs_req.address == OFS_RX_ID1) begin
      if (s_q.rx_full) rd_val = {24'h000000, s_q.rx_id[1]};               // R13
    end else if (avs_req.address == OFS_RX_ID2) begin
      if (s_q.rx_full) rd_val = {24'h000000, s_q.rx_id[2]};               // R13
    end else if (avs_req.address == OFS_RX_ID3) begin
      if (s_q.rx_full) rd_val = {24'h000000, s_q.rx_id[3]};               // R13
    end else if (avs_req.address == OFS_TX_ID0) begin
      if (tx_open) rd_val = {24'h000000, s_q.tx_id[sel_idx][0]};          // R13
    end else if (avs_req.address == OFS_TX_ID1) begin
      if (tx_open) rd_val = {24'h000000, s_q.tx_id[sel_idx][1]};          // R13
    end else if (avs_req.address == OFS_TX_ID2) begin
      if (tx_open) rd_val = {24'h000000, s_q.tx_id[sel_idx][2]};          // R13
    end else if (avs_req.address == OFS_TX_ID3) begin
      if (tx_open) rd_val = {24'h000000, s_q.tx_id[sel_idx][3]};          // R13
    end else if (avs_req.address == OFS_TX_SEL) begin
      rd_val = {29'h00000000, s_q.sel};
    end else if (avs_req.address == OFS_FLAGS) begin
      rd_val = {22'h000000, s_q.overrun, s_q.rx_full, 5'h00, s_q.empty};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit arbitration among queued buffers
  logic           arb_found;
  logic [TXW-1:0] arb_idx;
  logic [31:0]    arb_best;

  always_comb begin
    arb_found = 1'b0;
    arb_idx   = '0;
    arb_best  = 32'hFFFFFFFF;
    for (int i = 0; i < NTX; i++) begin
      // Strict less-than keeps the lower index on a tie
      if (!s_q.empty[i] && (!arb_found || pk_key[i] < arb_best)) begin    // R2
        arb_found = 1'b1;
        arb_idx   = TXW'(i);
        arb_best  = pk_key[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic           clr_rx;
  logic           clr_ovr;
  logic [NTX-1:0] sel_low;

  always_comb begin
    s_d     = s_q;
    s_d.ack = req_new;
    clr_rx  = wr_go && avs_req.address == OFS_FLAGS && avs_req.writedata[FL_RXFULL];
    clr_ovr = wr_go && avs_req.address == OFS_FLAGS && avs_req.writedata[FL_OVR];
    sel_low = wbyte[NTX-1:0] & (~wbyte[NTX-1:0] + 3'h1);

    // Answer latched one cycle before the master samples it
    if (req_new) begin
      s_d.rdata = avs_req.read ? rd_val : 32'h00000000;
    end

    // Register writes; receive bytes have no write path
    if (wr_go) begin
      if (avs_req.address == OFS_TX_ID0) begin
        if (tx_open) s_d.tx_id[sel_idx][0] = wbyte;                       // R13
      end else if (avs_req.address == OFS_TX_ID1) begin
        if (tx_open) s_d.tx_id[sel_idx][1] = wbyte;                       // R13
      end else if (avs_req.address == OFS_TX_ID2) begin
        if (tx_open) s_d.tx_id[sel_idx][2] = wbyte;                       // R13
      end else if (avs_req.address == OFS_TX_ID3) begin
        if (tx_open) s_d.tx_id[sel_idx][3] = wbyte;                       // R13
      end else if (avs_req.address == OFS_TX_SEL) begin
        s_d.sel = sel_low;       // Lowest requested buffer wins the window
      end else if (avs_req.address == OFS_FLAGS) begin
        // Writing 1 hands a buffer to the engine
        s_d.empty = s_q.empty & ~wbyte[NTX-1:0];
      end
    end

    // Clears first, so a same-cycle set survives
    if (clr_rx)  s_d.rx_full = 1'b0;
    if (clr_ovr) s_d.overrun = 1'b0;

    // Engine finished a buffer: back to software
    if (tx_done) begin
      s_d.empty[tx_done_idx] = 1'b1;
    end

    // Store only into a free buffer, else flag the loss
    if (rx_store) begin
      if (!s_q.rx_full || clr_rx) begin
        s_d.rx_id   = rx_bytes;                                           // R5 R7 R9
        s_d.rx_full = 1'b1;
      end else begin
        s_d.overrun = 1'b1;
      end
    end

    // Registered frame offer to the engine
    s_d.tx_valid = arb_found;
    s_d.tx_idx   = arb_idx;
    s_d.tx_frame = pk_frame[arb_idx];                                     // R4 R6 R8 R15
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; storage takes zero at reset though software may not rely on it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q          <= '0;                                                 // R14
      s_q.empty    <= RST_EMPTY;
      s_q.sel      <= RST_SEL;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata = s_q.rdata;
  assign tx_valid     = s_q.tx_valid;
  assign tx_idx       = s_q.tx_idx;
  assign tx_frame     = s_q.tx_frame;
  assign rx_full      = s_q.rx_full;
  assign rx_overrun   = s_q.overrun;

endmodule

`default_nettype wire

// File: common/cbim_pkg.sv
// Shared constants and carrier types for the CAN buffer identifier map.
// Assumes one 40 MHz clock and a 32-bit Avalon-MM slave port.
`default_nettype none

package cbim_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Buffer geometry
  localparam int unsigned NTX = 3;               // Transmit buffers
  localparam int unsigned TXW = 2;               // Index width of a transmit buffer

  ////////////////////////////////////////////////////////////////////////////
  // Byte addresses of the register map
  localparam logic [5:0] OFS_RX_ID0  = 6'h00;
  localparam logic [5:0] OFS_RX_ID1  = 6'h04;
  localparam logic [5:0] OFS_RX_ID2  = 6'h08;
  localparam logic [5:0] OFS_RX_ID3  = 6'h0C;
  localparam logic [5:0] OFS_TX_ID0  = 6'h10;
  localparam logic [5:0] OFS_TX_ID1  = 6'h14;
  localparam logic [5:0] OFS_TX_ID2  = 6'h18;
  localparam logic [5:0] OFS_TX_ID3  = 6'h1C;
  localparam logic [5:0] OFS_TX_SEL  = 6'h20;
  localparam logic [5:0] OFS_FLAGS   = 6'h24;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned B1_SRR     = 4;        // Extended mapping, ident_byte_1
  localparam int unsigned B1_IDE     = 3;        // Format flag, ident_byte_1
  localparam int unsigned B1_RTR_STD = 4;        // Standard mapping, ident_byte_1
  localparam int unsigned B3_RTR_EXT = 0;        // Extended mapping, ident_byte_3
  localparam int unsigned FL_RXFULL  = 8;        // Flags register, receive full
  localparam int unsigned FL_OVR     = 9;        // Flags register, receive overrun

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [NTX-1:0] RST_EMPTY = 3'h7;   // All transmit buffers free
  localparam logic [NTX-1:0] RST_SEL   = 3'h0;
  localparam logic [7:0]     RST_BYTE  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        ext;                            // 1: 29-bit identifier
    logic        srr;
    logic        rtr;
    logic [28:0] id;                             // Standard uses id[10:0]
  } cbim_frame_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } cbim_avs_req_t;

  typedef struct packed {
    logic [NTX-1:0][3:0][7:0] tx_id;
    logic [3:0][7:0]          rx_id;
    logic [NTX-1:0]           sel;
    logic [NTX-1:0]           empty;
    logic                     rx_full;
    logic                     overrun;
    logic                     ack;
    logic [31:0]              rdata;
    logic                     tx_valid;
    logic [TXW-1:0]           tx_idx;
    cbim_frame_t              tx_frame;
  } cbim_state_t;

endpackage

`default_nettype wire

// File: design/cbim_pack.sv
// Turns the four identifier bytes of one buffer into a frame header and
// an arbitration key. Purely combinational; the caller registers results.
`default_nettype none

module cbim_pack
  import cbim_pkg::*;
(
  input  wire logic [3:0][7:0] id_bytes,
  output cbim_frame_t          frame,
  output logic [31:0]          arb_key
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte layout to header fields
  always_comb begin
    frame.ext = id_bytes[1][B1_IDE];                                      // R6
    if (frame.ext) begin
      frame.id  = {id_bytes[0], id_bytes[1][7:5], id_bytes[1][2:0],
                   id_bytes[2], id_bytes[3][7:1]};                        // R1 R3
      frame.rtr = id_bytes[3][B3_RTR_EXT];                                // R8
      frame.srr = id_bytes[1][B1_SRR];                                    // R4
    end else begin
      // Bytes 2, 3 and low bits of byte 1 play no part here
      frame.id  = {18'h00000, id_bytes[0], id_bytes[1][7:5]};             // R10 R11 R12 R15
      frame.rtr = id_bytes[1][B1_RTR_STD];                                // R8 R12
      frame.srr = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key in bus bit order: a lower key wins arbitration
  always_comb begin
    if (frame.ext) begin
      arb_key = {frame.id[28:18], frame.srr, 1'b1, frame.id[17:0], frame.rtr}; // R2
    end else begin
      arb_key = {frame.id[10:0], frame.rtr, 1'b0, 19'h00000};             // R2
    end
  end

endmodule

`default_nettype wire

// File: design/cbim_unpack.sv
// Turns a received frame header into the four identifier bytes stored
// in the receive buffer. Purely combinational.
`default_nettype none

module cbim_unpack
  import cbim_pkg::*;
(
  input  wire cbim_frame_t     frame,
  output logic [3:0][7:0]      id_bytes
);

  ////////////////////////////////////////////////////////////////////////////
  // Header fields to byte layout; unused positions are stored as zero
  always_comb begin
    if (frame.ext) begin
      id_bytes[0] = frame.id[28:21];                                      // R1
      id_bytes[1] = {frame.id[20:18], frame.srr, 1'b1, frame.id[17:15]};  // R3 R5 R7
      id_bytes[2] = frame.id[14:7];                                       // R3
      id_bytes[3] = {frame.id[6:0], frame.rtr};                           // R3 R9
    end else begin
      id_bytes[0] = frame.id[10:3];                                       // R11
      id_bytes[1] = {frame.id[2:0], frame.rtr, 1'b0, 3'h0};               // R7 R9 R12
      id_bytes[2] = RST_BYTE;                                             // R14
      id_bytes[3] = RST_BYTE;                                             // R14
    end
  end

endmodule

`default_nettype wire

// File: dv/cbim_top_properties.sv
// Port-level checker for the identifier map block.
// Assumes it is bound onto cbim_top; ce drops only while the bus is idle.
`default_nettype none

module cbim_top_properties
  import cbim_pkg::*;
(
  input wire logic           clk,
  input wire logic           rstn,
  input wire logic           ce,
  input wire cbim_avs_req_t  avs_req,
  input wire logic [31:0]    avs_readdata,
  input wire logic           avs_waitrequest,
  input wire logic           tx_valid,
  input wire logic [TXW-1:0] tx_idx,
  input wire cbim_frame_t    tx_frame,
  input wire logic           tx_done,
  input wire logic [TXW-1:0] tx_done_idx,
  input wire logic           rx_store,
  input wire cbim_frame_t    rx_frame,
  input wire logic           rx_full,
  input wire logic           rx_overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  chk_one_wait: assert property (avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_rx_gate: assert property (avs_req.read && avs_waitrequest && !rx_full
    && avs_req.address < OFS_TX_ID0 |=> avs_readdata == 32'h0)
    else $error("receive byte visible while buffer not full");
  chk_hi_zero: assert property (avs_req.read && !avs_waitrequest
    && avs_req.address != OFS_FLAGS |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Transmit header; changes need a write or a done pulse first
  chk_std_width: assert property (tx_valid && !tx_frame.ext |-> tx_frame.id[28:11] == 18'h0)
    else $error("standard frame carries upper identifier bits");
  chk_std_srr: assert property (tx_valid && !tx_frame.ext |-> !tx_frame.srr)
    else $error("standard frame carries a substitute bit");
  chk_tx_stable: assert property ((!avs_req.write && !tx_done) [*4]
    |-> $stable(tx_frame) && $stable(tx_idx))
    else $error("transmit header changed with no cause");

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer
  chk_rx_fill: assert property (rx_store && !rx_full && ce |=> rx_full)
    else $error("store did not fill receive buffer");
  chk_rx_hold: assert property (rx_full && !avs_req.write |=> rx_full)
    else $error("receive buffer emptied without a write");
endmodule

bind cbim_top cbim_top_properties u_props (.clk, .rstn, .ce, .avs_req, .avs_readdata,
  .avs_waitrequest, .tx_valid, .tx_idx, .tx_frame, .tx_done, .tx_done_idx, .rx_store,
  .rx_frame, .rx_full, .rx_overrun);

`default_nettype wire

// File: dv/cbim_engine_model.sv
// Behavioural protocol engine facing the identifier map block.
// Assumes one clock; sends whichever buffer the block offers.
`default_nettype none

module cbim_engine_model
  import cbim_pkg::*;
(
  input wire logic           clk,
  input wire logic           tx_valid,
  input wire logic [TXW-1:0] tx_idx,
  input wire cbim_frame_t    tx_frame,
  output logic               tx_done,
  output logic [TXW-1:0]     tx_done_idx,
  output logic               rx_store,
  output cbim_frame_t        rx_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  int          lat = 1;
  logic [33:0] sent_q[$];

  // Arbitration sampled late, as just before start of frame
  initial begin
    tx_done = 1'b0;
    tx_done_idx = '0;
    rx_store = 1'b0;
    rx_frame = '0;
    forever begin
      @(posedge clk);
      if (tx_valid === 1'b1) begin
        repeat (lat) @(posedge clk);
        sent_q.push_back({tx_idx, tx_frame});
        tx_done <= 1'b1;
        tx_done_idx <= tx_idx;
        @(posedge clk);
        tx_done <= 1'b0;
        tx_done_idx <= ~tx_idx;
        // Flag and header take two cycles to follow
        repeat (2) @(posedge clk);
      end
    end
  end

  // One-cycle store; stale header is scrambled afterwards
  task automatic recv(input cbim_frame_t f);
    @(posedge clk);
    rx_store <= 1'b1;
    rx_frame <= f;
    @(posedge clk);
    rx_store <= 1'b0;
    rx_frame <= ~f;
  endtask
endmodule

`default_nettype wire

// File: dv/cbim_top_test.sv
// Self-checking bench for the identifier map block.
// Assumes the engine model and the bound checker are compiled alongside.
`default_nettype none

module cbim_top_test
  import cbim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk;
  logic           rstn;
  logic           ce;
  cbim_avs_req_t  avs_req;
  logic [31:0]    avs_readdata;
  logic           avs_waitrequest, tx_valid, tx_done, rx_store, rx_full, rx_overrun;
  logic [TXW-1:0] tx_idx, tx_done_idx;
  cbim_frame_t    tx_frame, rx_frame;
  int             fail_count = 0;
  int             checked = 0;
  int             cycles = 0;

  // Clock enable dropped only while the bus is idle
  cbim_top u_dut (.clk, .rstn, .ce, .avs_req, .avs_readdata, .avs_waitrequest,
    .tx_valid, .tx_idx, .tx_frame, .tx_done, .tx_done_idx, .rx_store, .rx_frame,
    .rx_full, .rx_overrun);
  cbim_engine_model u_eng (.clk, .tx_valid, .tx_idx, .tx_frame, .tx_done, .tx_done_idx,
    .rx_store, .rx_frame);

  ////////////////////////////////////////////////////////////////////////////
  // Expected byte images, byte 0 in the top lane
  function automatic logic [31:0] ext_bytes(logic [28:0] id, logic srr, logic rtr);
    return {id[28:21], id[20:18], srr, 1'b1, id[17:15], id[14:7], id[6:0], rtr};
  endfunction
  function automatic logic [31:0] std_bytes(logic [10:0] id, logic rtr);
    return {id[10:3], id[2:0], rtr, 1'b0, 19'h0};
  endfunction

  task automatic miss(input string m);
    fail_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) miss($sformatf("got %h expected %h", got, exp));
  endtask

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    avs_req.read <= !wr;
    avs_req.write <= wr;
    avs_req.address <= a;
    avs_req.writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) miss("no bus answer");
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp({2'b00, q}, {2'b00, e});
  endtask
  task automatic sent(input logic [1:0] k, input logic [31:0] e);
    int n = 0;
    while (u_eng.sent_q.size() == 0 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n == 500) miss("no frame sent");
    else cmp(u_eng.sent_q.pop_front(), {k, e});
    repeat (3) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_reset();
    rdc(OFS_FLAGS, 32'h7);
    rdc(OFS_RX_ID0, 32'h0);
    rdc(6'h28, 32'h0);
  endtask
  task automatic s_ext_prio();
    logic [28:0] ids [3] = '{29'h1000_0000, 29'h0000_0010, 29'h0000_0001};
    logic [31:0] v;
    u_eng.lat = 30;
    for (int k = 0; k < 3; k++) begin
      v = ext_bytes(ids[k], 1'b1, k[0]);
      wr(OFS_TX_SEL, 32'h1 << k);
      for (int b = 0; b < 4; b++) wr(6'(OFS_TX_ID0 + 4 * b), {24'h0, v[31-8*b -: 8]});
    end
    rdc(OFS_TX_ID1, {24'h0, v[23:16]});
    wr(OFS_FLAGS, 32'h7);
    for (int k = 2; k >= 0; k--) sent(k[1:0], {2'b11, k[0], ids[k]});
  endtask
  task automatic s_std();
    u_eng.lat = 1;
    wr(OFS_TX_SEL, 32'h2);
    wr(OFS_TX_ID0, 32'hA5);
    wr(OFS_TX_ID1, 32'hD7);
    wr(OFS_TX_ID2, 32'hFF);
    wr(OFS_TX_ID3, 32'hFF);
    wr(OFS_FLAGS, 32'h2);
    sent(2'h1, {3'b001, 18'h0, 8'hA5, 3'b110});
  endtask
  task automatic s_rx();
    cbim_frame_t f;
    logic [31:0] v;
    f = {3'b101, 29'h0ABC_DEF1};
    v = ext_bytes(f.id, 1'b0, 1'b1);
    u_eng.recv(f);
    rdc(OFS_FLAGS, 32'h107);
    for (int b = 0; b < 4; b++) rdc(6'(OFS_RX_ID0 + 4 * b), {24'h0, v[31-8*b -: 8]});
    u_eng.recv(~f);
    rdc(OFS_FLAGS, 32'h307);
    cmp({32'h0, rx_overrun, rx_full}, 34'h3);
    rdc(OFS_RX_ID0, {24'h0, v[31:24]});
    wr(OFS_FLAGS, 32'h300);
    f = {3'b000, 29'h0000_05A3};
    v = std_bytes(f.id[10:0], 1'b0);
    u_eng.recv(f);
    for (int b = 0; b < 4; b++) rdc(6'(OFS_RX_ID0 + 4 * b), {24'h0, v[31-8*b -: 8]});
    wr(OFS_FLAGS, 32'h100);
    rdc(OFS_RX_ID0, 32'h0);
  endtask
  task automatic s_access();
    wr(OFS_TX_SEL, 32'h6);
    rdc(OFS_TX_SEL, 32'h2);
    wr(OFS_TX_ID0, 32'h3C);
    u_eng.lat = 60;
    wr(OFS_FLAGS, 32'h2);
    rdc(OFS_TX_ID0, 32'h0);
    cmp({31'h0, tx_valid, tx_idx}, 34'h5);
    wr(OFS_TX_ID0, 32'h99);
    sent(2'h1, {3'b001, 18'h0, 8'h3C, 3'b110});
    rdc(OFS_TX_ID0, 32'h3C);
  endtask
  // Frozen block drops a store; a write without byte lane 0 is ignored
  task automatic s_freeze();
    @(posedge clk);
    ce <= 1'b0;
    u_eng.recv({3'b100, 29'h0000_0123});
    @(posedge clk);
    cmp({32'h0, rx_overrun, rx_full}, 34'h0);
    ce <= 1'b1;
    rdc(OFS_FLAGS, 32'h7);
    @(posedge clk);
    avs_req.byteenable <= 4'hE;
    wr(OFS_TX_SEL, 32'h1);
    @(posedge clk);
    avs_req.byteenable <= 4'hF;
    rdc(OFS_TX_SEL, 32'h2);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, sequence, hang guard and verdict
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    avs_req = '{read: 1'b0, write: 1'b0, address: 6'h0, writedata: 32'h0, byteenable: 4'hF};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    s_reset();
    s_ext_prio();
    s_std();
    s_rx();
    s_access();
    s_freeze();
    print_verdict();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miss("run timed out");
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
endmodule

`default_nettype wire
